// File: rtl/efscd_pkg.sv
// Functional notes
// - inrush doubling switch doubles high-set threshold
// - inhibit inverse-time when high-set stage started
// - high stage inhibit blocks start and trip
// - start latch switches hold low/high indications
// - residual voltage indication clears when zero
// - unit mode: current stages or voltage stages
// - deblocking applied when switch is zero and unit mode is current stages
// - direction mode: directional or non-directional
// - direction sense: forward or reverse
// - criterion and projection characteristic selection
// - sector switch: 80 or 88 degrees
// - angle presentation affects reporting only
// - curve select, lowest set switch wins
// - reset time select, lowest set switch wins
// - reset time 100 ms or more: intermittent
// - checksum is weighted sum of switches
package efscd_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_STAGE_FN   = 8'h00;
    localparam logic [7:0] OFS_DIR_MODE   = 8'h04;
    localparam logic [7:0] OFS_CURVE      = 8'h08;
    localparam logic [7:0] OFS_RESET_TIME = 8'h0C;
    localparam logic [7:0] OFS_STATUS     = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT   = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK   = 8'h18;
    localparam logic [7:0] OFS_CHECKSUM   = 8'h1C;
    // reset values
    localparam logic [7:0] RST_STAGE_FN   = 8'h00;
    localparam logic [7:0] RST_DIR_MODE   = 8'h00;
    localparam logic [7:0] RST_CURVE      = 8'h00;
    localparam logic [7:0] RST_RESET_TIME = 8'h00;
    // stage function switch positions
    localparam int SF_INRUSH_DBL = 0;
    localparam int SF_INV_INHIB  = 1;
    localparam int SF_HIGH_INHIB = 2;
    localparam int SF_LOW_LATCH  = 3;
    localparam int SF_HIGH_LATCH = 4;
    localparam int SF_RES_LATCH  = 5;
    localparam int SF_UNIT_MODE  = 6;
    localparam int SF_NO_DEBLOCK = 7;
    // directional switch positions
    localparam int DM_LOW_NONDIR  = 0;
    localparam int DM_LOW_REV     = 1;
    localparam int DM_HIGH_NONDIR = 2;
    localparam int DM_HIGH_REV    = 3;
    localparam int DM_CRITERION   = 4;
    localparam int DM_SECTOR      = 5;
    localparam int DM_COSINE      = 6;
    localparam int DM_ANGLE_PRES  = 7;
    // curve and reset time widths of used bits
    localparam int CURVE_BITS = 6;
    localparam int RTIME_BITS = 3;
    // sector half-widths in degrees
    localparam logic [6:0] SECTOR_NARROW_DEG = 7'd80;
    localparam logic [6:0] SECTOR_WIDE_DEG   = 7'd88;
    // reset times in ms
    localparam logic [10:0] RT_DEFAULT_MS = 11'd80;
    localparam logic [10:0] RT_SW1_MS     = 11'd100;
    localparam logic [10:0] RT_SW2_MS     = 11'd500;
    localparam logic [10:0] RT_SW3_MS     = 11'd1000;
    localparam logic [10:0] RT_INTERMIT_MS = 11'd100;
    // interrupt status bits
    localparam int IRQ_LOW_START  = 0;
    localparam int IRQ_HIGH_START = 1;
    localparam int IRQ_RES_START  = 2;
    localparam int IRQ_BITS       = 3;
    typedef enum logic [2:0] {
        EFSCD_CURVE_DT, EFSCD_CURVE_EI, EFSCD_CURVE_VI, EFSCD_CURVE_NI,
        EFSCD_CURVE_LI, EFSCD_CURVE_RI, EFSCD_CURVE_RD
    } efscd_curve_t;
endpackage : efscd_pkg

// File: rtl/efscd_decoder.sv
`timescale 1ns/1ps
module efscd_decoder (
    input  wire logic        clk,              // 25 MHz clock
    input  wire logic        rst,              // async reset, active high
    input  wire logic        psel,             // apb select
    input  wire logic        penable,          // apb enable
    input  wire logic        pwrite,           // apb direction
    input  wire logic [7:0]  paddr,            // apb byte address
    input  wire logic [31:0] pwdata,           // apb write data
    output logic      [31:0] prdata,           // apb read data
    output logic             pready,           // apb ready
    output logic             pslverr,          // apb error
    input  wire logic        inrush_pin,       // high inrush detected (async)
    input  wire logic        low_fault_pin,    // low-set stage fault (async)
    input  wire logic        high_fault_pin,   // high-set stage fault (async)
    input  wire logic        res_fault_pin,    // residual voltage fault (async)
    input  wire logic        ind_clear_pin,    // clear latched indications (async)
    output logic             threshold_double, // double high-set threshold
    output logic             inverse_inhibit,  // inverse-time suppressed
    output logic             high_stage_en,    // high stage enabled
    output logic             low_start_ind,    // low-set start indication
    output logic             high_start_ind,   // high-set start indication
    output logic             res_start_ind,    // residual start indication
    output logic             voltage_mode,     // three voltage stages
    output logic             deblock_en,       // residual deblocking used
    output logic             low_nondir,       // low-set non-directional
    output logic             low_reverse,      // low-set reverse
    output logic             high_nondir,      // high-set non-directional
    output logic             high_reverse,     // high-set reverse
    output logic             projected_crit,   // projected criterion
    output logic             cosine_char,      // cosine characteristic
    output logic      [6:0]  sector_deg,       // sector half-width in degrees
    output logic             angle_pres,       // reported angle selection
    output logic      [2:0]  curve_sel,        // selected curve code
    output logic      [10:0] reset_time_ms,    // selected reset time
    output logic             intermittent,     // intermittent earth-fault mode
    output logic             irq               // interrupt level
);
    typedef struct packed {
        logic [7:0]  stage_fn;
        logic [7:0]  dir_mode;
        logic [7:0]  curve;
        logic [7:0]  rtime;
        logic [4:0]  sync1;
        logic [4:0]  sync2;
        logic        low_ind;
        logic        high_ind;
        logic        res_ind;
        logic        high_start_d;
        logic        low_start_d;
        logic        res_start_d;
        logic [2:0]  irq_stat;
        logic [2:0]  irq_mask;
        logic [31:0] rdata;
        logic [2:0]  curve_q;
        logic [10:0] rtime_q;
    } efscd_state_t;

    efscd_state_t st_r;
    efscd_state_t st_nxt;

    logic        inrush_s;
    logic        low_f;
    logic        high_f;
    logic        res_f;
    logic        clr_s;
    logic        high_start;
    logic        low_start;
    logic        res_start;
    logic        wr_en;
    logic        rd_en;
    logic        addr_ok;
    logic [2:0]  curve_dec;
    logic [10:0] rtime_dec;
    logic [2:0]  irq_set;
    logic [31:0] chk_all;

    // second synchroniser stage is the only reader of the first
    assign inrush_s = st_r.sync2[0];
    assign low_f    = st_r.sync2[1];
    assign high_f   = st_r.sync2[2];
    assign res_f    = st_r.sync2[3];
    assign clr_s    = st_r.sync2[4];

    // stage qualification
    assign high_start = high_f & ~st_r.stage_fn[efscd_pkg::SF_HIGH_INHIB];
    assign low_start  = low_f;
    assign res_start  = res_f;

    // apb handshake: zero wait states
    assign pready  = 1'b1;
    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & ~penable & ~pwrite;
    assign addr_ok = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);
    assign pslverr = psel & penable & ~addr_ok;

    // curve decoder, lowest set switch wins, bits 7..8 ignored
    always_comb begin
        curve_dec = efscd_pkg::EFSCD_CURVE_DT;
        for (int i = efscd_pkg::CURVE_BITS - 1; i >= 0; i--) begin
            if (st_r.curve[i]) begin
                curve_dec = 3'(i + 1);
            end
        end
    end

    // reset time decoder, lowest set switch wins, bits 4..8 ignored
    always_comb begin
        if (st_r.rtime[0]) begin
            rtime_dec = efscd_pkg::RT_SW1_MS;
        end else if (st_r.rtime[1]) begin
            rtime_dec = efscd_pkg::RT_SW2_MS;
        end else if (st_r.rtime[2]) begin
            rtime_dec = efscd_pkg::RT_SW3_MS;
        end else begin
            rtime_dec = efscd_pkg::RT_DEFAULT_MS;
        end
    end

    // checksum of every switchgroup, weights 1..128, one byte lane per group
    always_comb begin
        logic [31:0] grps;
        grps    = {st_r.rtime, st_r.curve, st_r.dir_mode, st_r.stage_fn};
        chk_all = 32'h00000000;
        for (int g = 0; g < 4; g++) begin
            for (int i = 0; i < 8; i++) begin
                if (grps[g*8 + i]) begin
                    chk_all[g*8 +: 8] = chk_all[g*8 +: 8] + 8'(1 << i);
                end
            end
        end
    end

    // rising edges of qualified starts raise sticky interrupt bits
    assign irq_set = {res_start & ~st_r.res_start_d,
                      high_start & ~st_r.high_start_d,
                      low_start & ~st_r.low_start_d};

    // next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.sync1 = {ind_clear_pin, res_fault_pin, high_fault_pin,
                        low_fault_pin, inrush_pin};
        st_nxt.sync2 = st_r.sync1;
        st_nxt.high_start_d = high_start;
        st_nxt.low_start_d  = low_start;
        st_nxt.res_start_d  = res_start;
        st_nxt.curve_q = curve_dec;
        st_nxt.rtime_q = rtime_dec;
        // start indications follow the fault, or latch until cleared
        st_nxt.low_ind = low_start |
            (st_r.low_ind & st_r.stage_fn[efscd_pkg::SF_LOW_LATCH] & ~clr_s);
        st_nxt.high_ind = high_start |
            (st_r.high_ind & st_r.stage_fn[efscd_pkg::SF_HIGH_LATCH] & ~clr_s);
        st_nxt.res_ind = res_start |
            (st_r.res_ind & st_r.stage_fn[efscd_pkg::SF_RES_LATCH] & ~clr_s);
        // register writes
        if (wr_en) begin
            case (paddr)
                efscd_pkg::OFS_STAGE_FN:   st_nxt.stage_fn = pwdata[7:0];
                efscd_pkg::OFS_DIR_MODE:   st_nxt.dir_mode = pwdata[7:0];
                efscd_pkg::OFS_CURVE:      st_nxt.curve    = pwdata[7:0];
                efscd_pkg::OFS_RESET_TIME: st_nxt.rtime    = pwdata[7:0];
                efscd_pkg::OFS_IRQ_MASK:   st_nxt.irq_mask = pwdata[2:0];
                default:                   st_nxt.irq_mask = st_r.irq_mask;
            endcase
        end
        // sticky status: set wins over write-one-to-clear
        if (wr_en && paddr == efscd_pkg::OFS_IRQ_STAT) begin
            st_nxt.irq_stat = (st_r.irq_stat & ~pwdata[2:0]) | irq_set;
        end else begin
            st_nxt.irq_stat = st_r.irq_stat | irq_set;
        end
        // read data captured in setup phase
        if (rd_en) begin
            case (paddr)
                efscd_pkg::OFS_STAGE_FN:   st_nxt.rdata = {24'h000000, st_r.stage_fn};
                efscd_pkg::OFS_DIR_MODE:   st_nxt.rdata = {24'h000000, st_r.dir_mode};
                efscd_pkg::OFS_CURVE:      st_nxt.rdata = {24'h000000, st_r.curve};
                efscd_pkg::OFS_RESET_TIME: st_nxt.rdata = {24'h000000, st_r.rtime};
                efscd_pkg::OFS_STATUS:     st_nxt.rdata = {15'h0000, st_r.rtime_q,
                                                           st_r.curve_q, st_r.res_ind,
                                                           st_r.high_ind, st_r.low_ind};
                efscd_pkg::OFS_IRQ_STAT:   st_nxt.rdata = {29'h00000000, st_r.irq_stat};
                efscd_pkg::OFS_IRQ_MASK:   st_nxt.rdata = {29'h00000000, st_r.irq_mask};
                efscd_pkg::OFS_CHECKSUM:   st_nxt.rdata = chk_all;
                default:                   st_nxt.rdata = 32'h00000000;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
            st_r.stage_fn <= efscd_pkg::RST_STAGE_FN;
            st_r.dir_mode <= efscd_pkg::RST_DIR_MODE;
            st_r.curve    <= efscd_pkg::RST_CURVE;
            st_r.rtime    <= efscd_pkg::RST_RESET_TIME;
            st_r.rtime_q  <= efscd_pkg::RT_DEFAULT_MS;
        end else begin
            st_r <= st_nxt;
        end
    end

    // read data comes from the word captured in the setup phase
    assign prdata = st_r.rdata;

    // configuration outputs
    assign threshold_double = st_r.stage_fn[efscd_pkg::SF_INRUSH_DBL] & inrush_s;
    assign inverse_inhibit  = st_r.stage_fn[efscd_pkg::SF_INV_INHIB] & high_start;
    assign high_stage_en    = ~st_r.stage_fn[efscd_pkg::SF_HIGH_INHIB];
    assign low_start_ind    = st_r.low_ind;
    assign high_start_ind   = st_r.high_ind;
    assign res_start_ind    = st_r.res_ind;
    assign voltage_mode     = st_r.stage_fn[efscd_pkg::SF_UNIT_MODE];
    assign deblock_en       = ~st_r.stage_fn[efscd_pkg::SF_NO_DEBLOCK] &
                              ~st_r.stage_fn[efscd_pkg::SF_UNIT_MODE];
    assign low_nondir       = st_r.dir_mode[efscd_pkg::DM_LOW_NONDIR];
    assign high_nondir      = st_r.dir_mode[efscd_pkg::DM_HIGH_NONDIR];
    assign low_reverse      = st_r.dir_mode[efscd_pkg::DM_LOW_REV];
    assign high_reverse     = st_r.dir_mode[efscd_pkg::DM_HIGH_REV];
    assign projected_crit   = st_r.dir_mode[efscd_pkg::DM_CRITERION];
    assign cosine_char      = st_r.dir_mode[efscd_pkg::DM_COSINE];
    assign sector_deg       = st_r.dir_mode[efscd_pkg::DM_SECTOR] ?
                              efscd_pkg::SECTOR_WIDE_DEG :
                              efscd_pkg::SECTOR_NARROW_DEG;
    assign angle_pres       = st_r.dir_mode[efscd_pkg::DM_ANGLE_PRES];
    assign curve_sel        = st_r.curve_q;
    assign reset_time_ms    = st_r.rtime_q;
    assign intermittent     = (st_r.rtime_q >= efscd_pkg::RT_INTERMIT_MS);
    assign irq              = |(st_r.irq_stat & st_r.irq_mask);

    // assertions
    property p_double;
        @(posedge clk) disable iff (rst)
        threshold_double |-> (st_r.stage_fn[0] && inrush_s);
    endproperty
    a_double: assert property (p_double) else $error("doubling without switch");

    property p_inv;
        @(posedge clk) disable iff (rst)
        (st_r.stage_fn[1] && high_start) |-> inverse_inhibit;
    endproperty
    a_inv: assert property (p_inv) else $error("inverse not inhibited");

    property p_inhib;
        @(posedge clk) disable iff (rst)
        st_r.stage_fn[2] && $past(st_r.stage_fn[2]) |-> !high_start && !irq_set[1];
    endproperty
    a_inhib: assert property (p_inhib) else $error("inhibited stage started");

    property p_unlatch;
        @(posedge clk) disable iff (rst)
        (!st_r.stage_fn[3] && !low_start) |=> !st_r.low_ind;
    endproperty
    a_unlatch: assert property (p_unlatch) else $error("low indication not cleared");

    property p_latch;
        @(posedge clk) disable iff (rst)
        (st_r.stage_fn[4] && st_r.high_ind && !clr_s) |=> st_r.high_ind;
    endproperty
    a_latch: assert property (p_latch) else $error("high indication lost");

    property p_res;
        @(posedge clk) disable iff (rst)
        (!st_r.stage_fn[5] && !res_start) |=> !res_start_ind;
    endproperty
    a_res: assert property (p_res) else $error("residual indication stuck");

    property p_curve;
        @(posedge clk) disable iff (rst)
        (st_r.curve[0] && $stable(st_r.curve)) |=> curve_sel == 3'h1;
    endproperty
    a_curve: assert property (p_curve) else $error("curve priority wrong");

    property p_rtime;
        @(posedge clk) disable iff (rst)
        (st_r.rtime[2:0] == 3'h6) |=> reset_time_ms == 11'd500;
    endproperty
    a_rtime: assert property (p_rtime) else $error("reset time priority wrong");

    property p_intm;
        @(posedge clk) disable iff (rst)
        intermittent == (reset_time_ms != 11'd80);
    endproperty
    a_intm: assert property (p_intm) else $error("intermittent mode wrong");

    property p_sector;
        @(posedge clk) disable iff (rst)
        sector_deg == (st_r.dir_mode[5] ? 7'd88 : 7'd80);
    endproperty
    a_sector: assert property (p_sector) else $error("sector wrong");

    c_latch: cover property (@(posedge clk) disable iff (rst)
        st_r.stage_fn[3] && st_r.low_ind && !low_start);
    c_irq: cover property (@(posedge clk) disable iff (rst) irq);
    c_curve_rd: cover property (@(posedge clk) disable iff (rst) curve_sel == 3'h6);
endmodule : efscd_decoder

// File: sim/efscd_decoder_tb.sv
`timescale 1ns/1ps
module efscd_decoder_tb;
    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [4:0]  pin_r;       // clear, res, high, low, inrush
    logic        threshold_double, inverse_inhibit, high_stage_en;
    logic        low_start_ind, high_start_ind, res_start_ind;
    logic        voltage_mode, deblock_en, low_nondir, low_reverse;
    logic        high_nondir, high_reverse, projected_crit, cosine_char;
    logic [6:0]  sector_deg;
    logic        angle_pres;
    logic [2:0]  curve_sel;
    logic [10:0] reset_time_ms;
    logic        intermittent;
    logic        irq;
    int          errors;
    int          comparisons;
    int          ticks;
    logic [2:0]  ind;
    logic [7:0]  curves [10] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20,
                                 8'h3F, 8'hC0, 8'hC6};
    logic [7:0]  rtimes [8] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h07, 8'h06, 8'hF8, 8'hFC};
    logic [7:0]  v;
    logic [10:0] rt;
    logic [2:0]  cv;

    assign ind = {res_start_ind, high_start_ind, low_start_ind};

    efscd_decoder efscd_decoder_i (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .inrush_pin(pin_r[0]), .low_fault_pin(pin_r[1]),
        .high_fault_pin(pin_r[2]), .res_fault_pin(pin_r[3]), .ind_clear_pin(pin_r[4]),
        .threshold_double(threshold_double), .inverse_inhibit(inverse_inhibit),
        .high_stage_en(high_stage_en), .low_start_ind(low_start_ind),
        .high_start_ind(high_start_ind), .res_start_ind(res_start_ind),
        .voltage_mode(voltage_mode), .deblock_en(deblock_en), .low_nondir(low_nondir),
        .low_reverse(low_reverse), .high_nondir(high_nondir), .high_reverse(high_reverse),
        .projected_crit(projected_crit), .cosine_char(cosine_char),
        .sector_deg(sector_deg), .angle_pres(angle_pres), .curve_sel(curve_sel),
        .reset_time_ms(reset_time_ms), .intermittent(intermittent), .irq(irq)
    );

    // free running clock, 40 ns period
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // verdict and end of run
    task automatic wrap_up;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up

    // hang guard, far above the expected run length
    initial begin
        ticks = 0;
        forever begin
            @(posedge clk);
            ticks++;
            if (ticks == 20000) begin
                errors++;
                wrap_up();
            end
        end
    end

    // compare one value against its expectation
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // wait n edges, then step past the edge so outputs are settled
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    // one apb transfer: setup, access until pready, then release
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, {24'h000000, d}, rd, err);
        cyc(2);
    endtask : wr

    // read and compare data and error response
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h00000000, rd, err);
        chk(rd, exp);
        chk({31'h0, err}, {31'h0, eerr});
    endtask : rd_chk

    // drive one pin at a rising edge and let the synchroniser settle
    task automatic pin(input int i, input logic val);
        @(posedge clk);
        pin_r[i] <= val;
        cyc(5);
    endtask : pin

    initial begin
        errors = 0;
        comparisons = 0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        pin_r = 5'h00;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        // reset values and refused address
        rd_chk(efscd_pkg::OFS_STAGE_FN, 32'h00000000, 1'b0);
        rd_chk(efscd_pkg::OFS_DIR_MODE, 32'h00000000, 1'b0);
        chk({21'h0, reset_time_ms}, 32'd80);
        chk({29'h0, curve_sel}, 32'h00000000);
        rd_chk(efscd_pkg::OFS_STATUS, {15'h0000, 11'h050, 6'h00}, 1'b0);
        rd_chk(8'hE0, 32'h00000000, 1'b1);
        $display("test reset done");
        // stage function switches one at a time
        for (int i = 0; i < 8; i++) begin
            wr(efscd_pkg::OFS_STAGE_FN, 8'h01 << i);
            rd_chk(efscd_pkg::OFS_STAGE_FN, 32'h1 << i, 1'b0);
            rd_chk(efscd_pkg::OFS_CHECKSUM, 32'h1 << i, 1'b0);
            chk({29'h0, voltage_mode, high_stage_en, deblock_en},
                {29'h0, i == 6, i != 2, i != 6 && i != 7});
        end
        $display("test stage function done");
        // directional switches one at a time
        for (int i = 0; i < 8; i++) begin
            wr(efscd_pkg::OFS_DIR_MODE, 8'h01 << i);
            chk({24'h0, angle_pres, cosine_char, 1'b0, projected_crit, high_reverse,
                 high_nondir, low_reverse, low_nondir},
                (32'h1 << i) & 32'hDF);
            chk({25'h0, sector_deg}, (i == 5) ? 32'd88 : 32'd80);
        end
        $display("test directional done");
        // curve selection with priority and unused bits
        foreach (curves[k]) begin
            v = curves[k];
            cv = 3'd0;
            for (int b = 5; b >= 0; b--) if (v[b]) cv = 3'(b + 1);
            wr(efscd_pkg::OFS_CURVE, v);
            chk({29'h0, curve_sel}, {29'h0, cv});
        end
        $display("test curve done");
        // reset time selection and intermittent mode
        foreach (rtimes[k]) begin
            v = rtimes[k];
            rt = v[0] ? 11'd100 : v[1] ? 11'd500 : v[2] ? 11'd1000 : 11'd80;
            wr(efscd_pkg::OFS_RESET_TIME, v);
            chk({21'h0, reset_time_ms}, {21'h0, rt});
            chk({31'h0, intermittent}, {31'h0, rt >= 11'd100});
        end
        // all four checksums, the directional group set to switches 1, 3, 5, 7
        wr(efscd_pkg::OFS_DIR_MODE, 8'h55);
        rd_chk(efscd_pkg::OFS_CHECKSUM, {8'hFC, 8'hC6, 8'd85, 8'h80}, 1'b0);
        $display("test reset time done");
        // inrush doubling, inverse inhibit, high stage inhibit
        wr(efscd_pkg::OFS_STAGE_FN, 8'h00);
        pin(0, 1'b1);
        chk({31'h0, threshold_double}, 32'h0);
        wr(efscd_pkg::OFS_STAGE_FN, 8'h03);
        chk({31'h0, threshold_double}, 32'h1);
        pin(0, 1'b0);
        chk({31'h0, threshold_double}, 32'h0);
        pin(2, 1'b1);
        chk({31'h0, inverse_inhibit}, 32'h1);
        wr(efscd_pkg::OFS_STAGE_FN, 8'h06);
        chk({30'h0, inverse_inhibit, high_start_ind}, 32'h0);
        pin(2, 1'b0);
        $display("test stage control done");
        // indication release per stage, latching for low and high stages
        for (int i = 0; i < 3; i++) begin
            wr(efscd_pkg::OFS_STAGE_FN, 8'h00);
            pin(i + 1, 1'b1);
            chk({31'h0, ind[i]}, 32'h1);
            pin(i + 1, 1'b0);
            chk({31'h0, ind[i]}, 32'h0);
            if (i < 2) begin
                wr(efscd_pkg::OFS_STAGE_FN, 8'h08 << i);
                pin(i + 1, 1'b1);
                pin(i + 1, 1'b0);
                chk({31'h0, ind[i]}, 32'h1);
                pin(4, 1'b1);
                pin(4, 1'b0);
                chk({31'h0, ind[i]}, 32'h0);
            end
        end
        $display("test indications done");
        // interrupt raise, mask and clear
        wr(efscd_pkg::OFS_STAGE_FN, 8'h00);
        wr(efscd_pkg::OFS_IRQ_STAT, 8'h07);
        rd_chk(efscd_pkg::OFS_IRQ_STAT, 32'h0, 1'b0);
        wr(efscd_pkg::OFS_IRQ_MASK, 8'h01);
        chk({31'h0, irq}, 32'h0);
        pin(1, 1'b1);
        pin(1, 1'b0);
        chk({31'h0, irq}, 32'h1);
        pin(2, 1'b1);
        pin(2, 1'b0);
        rd_chk(efscd_pkg::OFS_IRQ_STAT, 32'h3, 1'b0);
        wr(efscd_pkg::OFS_IRQ_STAT, 8'h01);
        chk({31'h0, irq}, 32'h0);
        rd_chk(efscd_pkg::OFS_IRQ_STAT, 32'h2, 1'b0);
        wr(efscd_pkg::OFS_IRQ_MASK, 8'h02);
        chk({31'h0, irq}, 32'h1);
        wr(efscd_pkg::OFS_IRQ_STAT, 8'h02);
        chk({31'h0, irq}, 32'h0);
        $display("test interrupt done");
        wrap_up();
    end
endmodule : efscd_decoder_tb
